// ### rtl/ppd_pkg.sv
package ppd_pkg;

  // ==========================================================
  // Bus and register map
  localparam int ADDR_W = 13; // 8 Kbyte space
  localparam logic [2:0] OFS_A_DATA = 3'h0;
  localparam logic [2:0] OFS_B_DATA = 3'h1;
  localparam logic [2:0] OFS_C_DATA = 3'h2;
  localparam logic [2:0] OFS_D_DATA = 3'h3;
  localparam logic [2:0] OFS_A_DIR = 3'h4;
  localparam logic [2:0] OFS_B_DIR = 3'h5;
  localparam logic [2:0] OFS_C_DIR = 3'h6;
  localparam logic [2:0] OFS_D_DIR = 3'h7;
  localparam logic [7:0] DIR_RESET = 8'h00;

  // ==========================================================
  // Implemented bit positions of each port
  localparam logic [7:0] A_IMPL = 8'hff;
  localparam logic [7:0] B_IMPL = 8'he0; // Bits 5..7
  localparam logic [7:0] C_IMPL = 8'hff;
  localparam logic [7:0] D_IMPL = 8'ha0; // Bits 5 and 7
  localparam logic [7:0] D_DRIVE = 8'h20; // Bit 7 is input only
  localparam int D_IO_BIT = 5;
  localparam int D_CAP_BIT = 7;
  localparam int B_LOW_BIT = 5;

  // ==========================================================
  // Address map
  localparam logic [12:0] IO_LAST = 13'h001f;
  localparam logic [12:0] PZ_ROM_FIRST = 13'h0020;
  localparam logic [12:0] PZ_ROM_LAST = 13'h004f;
  localparam logic [12:0] RAM_FIRST = 13'h0050;
  localparam logic [12:0] RAM_LAST = 13'h00ff;
  localparam logic [12:0] STACK_FIRST = 13'h00c0;
  localparam logic [12:0] MAIN_ROM_FIRST = 13'h0100;
  localparam logic [12:0] MAIN_ROM_LAST = 13'h10ff;
  localparam logic [12:0] SCHK_FIRST = 13'h1f00;
  localparam logic [12:0] SCHK_LAST = 13'h1fef;
  localparam logic [12:0] VEC_FIRST = 13'h1ff0;
  localparam logic [12:0] SECURE_FIRST = 13'h0028; // Customer code start
  localparam int RAM_DEPTH = 176;
  localparam int OSC_PER_BUS = 2; // Oscillator cycles per bus cycle

  // Region seen by the decoder
  typedef enum logic [2:0] {
    REG_IO, REG_PZ_ROM, REG_RAM, REG_MAIN_ROM, REG_SELFCHK, REG_VECTORS, REG_NONE
  } ppd_region_t;

endpackage : ppd_pkg

// ### rtl/ppd_port.sv
module ppd_port #(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] DRIVE = 8'hff
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_wr_data,
  input wire logic i_wr_dir,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_pin,
  output logic [7:0] o_latch,
  output logic [7:0] o_dir,
  output logic [7:0] o_oe_n,
  output logic [7:0] o_rd_data
);
  import ppd_pkg::*;

  logic [7:0] next_latch;
  logic [7:0] next_dir;

  // ==========================================================
  // Next values of latch and direction
  always_comb begin
    next_latch = o_latch;
    next_dir = o_dir;
    if (i_wr_data) begin
      next_latch = i_wdata & IMPL; // Latch written whatever the direction
    end
    if (i_wr_dir) begin
      next_dir = i_wdata & IMPL & DRIVE; // Input-only bits stay zero
    end
  end

  // Data latch keeps its value through reset
  always_ff @(posedge i_mclk) begin
    o_latch <= next_latch;
  end

  // Direction clears on reset, pins become inputs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dir <= DIR_RESET;
      o_oe_n <= ~DIR_RESET;
    end else begin
      o_dir <= next_dir;
      o_oe_n <= ~next_dir; // Zero drives the pin
    end
  end

  // Read: latch for outputs, pin for inputs
  assign o_rd_data = IMPL & ((o_dir & o_latch) | (~o_dir & i_pin));

endmodule : ppd_port

// ### rtl/ppd_ram.sv
module ppd_ram #(
  parameter int DEPTH = 176,
  parameter int AW = 8
) (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  import ppd_pkg::*;

  logic [7:0] mem [DEPTH];

  // ==========================================================
  // Synchronous write, registered read
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule : ppd_ram

// ### rtl/ppd_top.sv
module ppd_top #(
  parameter logic [7:0] KEYSCAN_MASK = 8'h00 // Fabrication option per port A pin
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [ppd_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output ppd_pkg::ppd_region_t o_region,
  output logic o_stack_win,
  output logic o_secure_area,
  input wire logic [7:0] i_keyscan_port_pin,
  output logic [7:0] o_keyscan_port_pin,
  output logic [7:0] o_keyscan_port_pin_oe_n,
  output logic [7:0] o_keyscan_pullup_en,
  output logic o_keyscan_irq_n,
  input wire logic [2:0] i_serial_shared_pin,
  output logic [2:0] o_serial_shared_pin,
  output logic [2:0] o_serial_shared_pin_oe_n,
  input wire logic [7:0] i_high_drive_port_pin,
  output logic [7:0] o_high_drive_port_pin,
  output logic [7:0] o_high_drive_port_pin_oe_n,
  input wire logic i_fourth_port_io_pin,
  output logic o_fourth_port_io_pin,
  output logic o_fourth_port_io_pin_oe_n,
  input wire logic i_capture_input_pin,
  output logic o_capture_level
);
  import ppd_pkg::*;

  // ==========================================================
  // Decode
  function automatic ppd_region_t ppd_decode(input logic [ADDR_W-1:0] a);
    if (a <= IO_LAST) begin
      ppd_decode = REG_IO;
    end else if (a <= PZ_ROM_LAST) begin
      ppd_decode = REG_PZ_ROM;
    end else if (a <= RAM_LAST) begin
      ppd_decode = REG_RAM;
    end else if (a <= MAIN_ROM_LAST) begin
      ppd_decode = REG_MAIN_ROM;
    end else if (a >= SCHK_FIRST && a <= SCHK_LAST) begin
      ppd_decode = REG_SELFCHK;
    end else if (a >= VEC_FIRST) begin
      ppd_decode = REG_VECTORS;
    end else begin
      ppd_decode = REG_NONE; // Holes in the 8 Kbyte space
    end
  endfunction : ppd_decode

  ppd_region_t region;
  logic io_reg;
  logic [2:0] io_ofs;
  logic [7:0] wr_data_sel;
  logic [7:0] wr_dir_sel;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_c;
  logic [7:0] rd_d;
  logic [7:0] lat_a;
  logic [7:0] lat_b;
  logic [7:0] lat_c;
  logic [7:0] lat_d;
  logic [7:0] dir_a;
  logic [7:0] oen_a;
  logic [7:0] oen_b;
  logic [7:0] oen_c;
  logic [7:0] oen_d;
  logic [7:0] pin_b;
  logic [7:0] pin_d;
  logic [7:0] ram_rdata;
  logic [7:0] ram_addr;
  logic ram_we;

  assign region = ppd_decode(i_addr);
  assign io_reg = (region == REG_IO) && (i_addr[ADDR_W-1:3] == '0);
  assign io_ofs = i_addr[2:0];
  assign ram_we = i_wr && (region == REG_RAM);
  assign ram_addr = 8'(i_addr[7:0] - RAM_FIRST[7:0]);
  assign pin_b = {i_serial_shared_pin, 5'h00};
  assign pin_d = {i_capture_input_pin, 1'b0, i_fourth_port_io_pin, 5'h00};

  // Write strobes, one per data and direction register
  always_comb begin
    wr_data_sel = 8'h00;
    wr_dir_sel = 8'h00;
    if (i_wr && io_reg) begin
      case (io_ofs)
        OFS_A_DATA, OFS_B_DATA, OFS_C_DATA, OFS_D_DATA: begin
          wr_data_sel[io_ofs[1:0]] = 1'b1;
        end
        default: begin
          wr_dir_sel[io_ofs[1:0]] = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Ports
  ppd_port #(.IMPL(A_IMPL), .DRIVE(A_IMPL)) u_port_a (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_data(wr_data_sel[0]), .i_wr_dir(wr_dir_sel[0]),
    .i_wdata(i_wdata), .i_pin(i_keyscan_port_pin), .o_latch(lat_a), .o_dir(dir_a),
    .o_oe_n(oen_a), .o_rd_data(rd_a)
  );
  ppd_port #(.IMPL(B_IMPL), .DRIVE(B_IMPL)) u_port_b (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_data(wr_data_sel[1]), .i_wr_dir(wr_dir_sel[1]),
    .i_wdata(i_wdata), .i_pin(pin_b), .o_latch(lat_b), .o_dir(),
    .o_oe_n(oen_b), .o_rd_data(rd_b)
  );
  ppd_port #(.IMPL(C_IMPL), .DRIVE(C_IMPL)) u_port_c (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_data(wr_data_sel[2]), .i_wr_dir(wr_dir_sel[2]),
    .i_wdata(i_wdata), .i_pin(i_high_drive_port_pin), .o_latch(lat_c), .o_dir(),
    .o_oe_n(oen_c), .o_rd_data(rd_c)
  );
  ppd_port #(.IMPL(D_IMPL), .DRIVE(D_DRIVE)) u_port_d (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wr_data(wr_data_sel[3]), .i_wr_dir(wr_dir_sel[3]),
    .i_wdata(i_wdata), .i_pin(pin_d), .o_latch(lat_d), .o_dir(),
    .o_oe_n(oen_d), .o_rd_data(rd_d)
  );

  // Pin outputs straight from the port flip-flops
  assign o_keyscan_port_pin = lat_a;
  assign o_keyscan_port_pin_oe_n = oen_a;
  assign o_serial_shared_pin = lat_b[7:B_LOW_BIT];
  assign o_serial_shared_pin_oe_n = oen_b[7:B_LOW_BIT];
  assign o_high_drive_port_pin = lat_c;
  assign o_high_drive_port_pin_oe_n = oen_c;
  assign o_fourth_port_io_pin = lat_d[D_IO_BIT];
  assign o_fourth_port_io_pin_oe_n = oen_d[D_IO_BIT];

  // ==========================================================
  // RAM
  ppd_ram #(.DEPTH(RAM_DEPTH), .AW(8)) u_ram (
    .i_mclk(i_mclk), .i_we(ram_we), .i_addr(ram_addr), .i_wdata(i_wdata), .o_rdata(ram_rdata)
  );

  // ==========================================================
  // Read pipeline and status flags
  logic rd_pend;
  logic rd_from_ram;
  logic [7:0] io_q;
  logic next_rd_pend;
  logic next_rd_from_ram;
  logic [7:0] next_io_q;
  logic [7:0] next_rdata;
  logic next_stack_win;
  logic next_secure;
  logic next_irq_n;
  logic [7:0] io_rd;

  // Register read selection
  always_comb begin
    case (io_ofs)
      OFS_A_DATA: io_rd = rd_a;
      OFS_B_DATA: io_rd = rd_b;
      OFS_C_DATA: io_rd = rd_c;
      OFS_D_DATA: io_rd = rd_d; // Capture pin always visible
      OFS_A_DIR: io_rd = dir_a;
      OFS_B_DIR: io_rd = ~oen_b & B_IMPL;
      OFS_C_DIR: io_rd = ~oen_c;
      OFS_D_DIR: io_rd = ~oen_d & D_IMPL;
      default: io_rd = 8'h00;
    endcase
  end

  // Next values: stage one captures I/O data, stage two presents it
  always_comb begin
    next_rd_pend = i_rd;
    next_rd_from_ram = i_rd && (region == REG_RAM);
    next_io_q = (i_rd && io_reg) ? io_rd : 8'h00; // ROM and holes read as zero here
    next_rdata = o_rdata;
    if (rd_pend) begin
      next_rdata = rd_from_ram ? ram_rdata : io_q;
    end
    next_stack_win = (region == REG_RAM) && (i_addr >= STACK_FIRST);
    next_secure = (i_addr >= SECURE_FIRST) && (i_addr <= PZ_ROM_LAST);
    next_irq_n = ~|(KEYSCAN_MASK & ~dir_a & ~i_keyscan_port_pin); // Outputs drop out
  end

  // Register the pipeline and flags
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_pend <= 1'b0;
      rd_from_ram <= 1'b0;
      io_q <= 8'h00;
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_region <= REG_IO;
      o_stack_win <= 1'b0;
      o_secure_area <= 1'b0;
      o_keyscan_irq_n <= 1'b1;
      o_keyscan_pullup_en <= KEYSCAN_MASK;
      o_capture_level <= 1'b0;
    end else begin
      rd_pend <= next_rd_pend;
      rd_from_ram <= next_rd_from_ram;
      io_q <= next_io_q;
      o_rdata <= next_rdata;
      o_rvalid <= rd_pend;
      o_region <= region;
      o_stack_win <= next_stack_win;
      o_secure_area <= next_secure;
      o_keyscan_irq_n <= next_irq_n;
      o_keyscan_pullup_en <= KEYSCAN_MASK;
      o_capture_level <= i_capture_input_pin; // Timer sees the pin too
    end
  end

endmodule : ppd_top

// ### sim/ppd_monitor.sv
module ppd_monitor
  import ppd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic o_rvalid,
  input wire ppd_region_t o_region,
  input wire logic o_stack_win,
  input wire logic [7:0] o_keyscan_port_pin,
  input wire logic [7:0] o_keyscan_port_pin_oe_n,
  input wire logic [7:0] o_high_drive_port_pin_oe_n,
  input wire logic i_capture_input_pin,
  input wire logic o_capture_level
);
  // ==========================================================
  // Bus timing
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_rd_req;
    i_rd;
  endsequence
  // Answer two edges after the request; back-to-back reads are legal
  sequence s_rd_answer;
    ##2 o_rvalid;
  endsequence
  a_rd_answer: assert property (s_rd_req |-> s_rd_answer)
    else $error("read answer missing");
  a_no_spurious: assert property (o_rvalid |-> $past(i_rd, 2))
    else $error("answer without read");
  // ==========================================================
  // Port behaviour
  a_dir_a_oe: assert property (
    i_wr && i_addr == 13'h0004 |=> o_keyscan_port_pin_oe_n == ~$past(i_wdata))
    else $error("port A enable wrong");
  a_dir_c_oe: assert property (
    i_wr && i_addr == 13'h0006 |=> o_high_drive_port_pin_oe_n == ~$past(i_wdata))
    else $error("port C enable wrong");
  a_latch_a: assert property (
    i_wr && i_addr == 13'h0000 |=> o_keyscan_port_pin == $past(i_wdata))
    else $error("port A latch wrong");
  a_capture_seen: assert property (1'b1 |=> o_capture_level == $past(i_capture_input_pin))
    else $error("capture level wrong");
  // ==========================================================
  // Decode
  a_region_io: assert property (i_addr <= 13'h001f |=> o_region == REG_IO)
    else $error("io decode wrong");
  a_region_pz: assert property (
    i_addr inside {[13'h0020:13'h004f]} |=> o_region == REG_PZ_ROM)
    else $error("page zero decode wrong");
  a_region_chk: assert property (
    i_addr inside {[13'h1f00:13'h1fef]} |=> o_region == REG_SELFCHK)
    else $error("self-check decode wrong");
  a_stack_flag: assert property (
    1'b1 |=> o_stack_win == ($past(i_addr) inside {[13'h00c0:13'h00ff]}))
    else $error("stack flag wrong");
endmodule : ppd_monitor

// ### sim/ppd_pin_model.sv
module ppd_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe_n,
  input wire logic [W-1:0] i_pattern,
  output logic [W-1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins show the port level, released pins the outside pattern
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_pattern);
endmodule : ppd_pin_model

// ### sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ppd_pkg::*;
  logic i_mclk = 1'b0, i_rstn = 1'b0, i_rd = 1'b0, i_wr = 1'b0, i_cap = 1'b0;
  logic [12:0] i_addr = 13'h0000;
  logic [7:0] i_wdata = 8'h00, o_rdata, pat_a = 8'h3c, pat_c = 8'h0f;
  logic [7:0] a_in, a_out, a_oe_n, c_in, c_out, c_oe_n;
  logic [2:0] b_in, b_out, b_oe_n, pat_b = 3'h2;
  logic d_in, d_out, d_oe_n, o_rvalid, o_irq_n, pat_d = 1'b0;
  logic o_stack, o_secure, cap_lvl;
  logic [7:0] o_pull;
  ppd_region_t o_region;
  int error_cnt = 0, checks = 0;
  ppd_top #(.KEYSCAN_MASK(8'h01)) dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_region(o_region), .o_stack_win(o_stack), .o_secure_area(o_secure),
    .i_keyscan_port_pin(a_in),
    .o_keyscan_port_pin(a_out), .o_keyscan_port_pin_oe_n(a_oe_n), .o_keyscan_pullup_en(o_pull),
    .o_keyscan_irq_n(o_irq_n), .i_serial_shared_pin(b_in), .o_serial_shared_pin(b_out),
    .o_serial_shared_pin_oe_n(b_oe_n), .i_high_drive_port_pin(c_in),
    .o_high_drive_port_pin(c_out), .o_high_drive_port_pin_oe_n(c_oe_n),
    .i_fourth_port_io_pin(d_in), .o_fourth_port_io_pin(d_out),
    .o_fourth_port_io_pin_oe_n(d_oe_n), .i_capture_input_pin(i_cap), .o_capture_level(cap_lvl));
  ppd_pin_model #(.W(8)) u_pa (.i_out(a_out), .i_oe_n(a_oe_n), .i_pattern(pat_a), .o_pin(a_in));
  ppd_pin_model #(.W(3)) u_pb (.i_out(b_out), .i_oe_n(b_oe_n), .i_pattern(pat_b), .o_pin(b_in));
  ppd_pin_model #(.W(8)) u_pc (.i_out(c_out), .i_oe_n(c_oe_n), .i_pattern(pat_c), .o_pin(c_in));
  ppd_pin_model #(.W(1)) u_pd (.i_out(d_out), .i_oe_n(d_oe_n), .i_pattern(pat_d), .o_pin(d_in));
  // Clock
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1 i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(posedge i_mclk);
    #1 i_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    #1 i_rd = 1'b1;
    i_addr = a;
    @(posedge i_mclk);
    #1 i_rd = 1'b0;
    for (int n = 0; n < 4 && o_rvalid !== 1'b1; n++) begin
      @(posedge i_mclk);
      #1;
    end
    chk("rvalid", {7'h00, o_rvalid}, 8'h01);
    chk($sformatf("read %h", a), o_rdata, e);
  endtask : rd
  task automatic dec(input logic [12:0] a, input ppd_region_t r);
    @(posedge i_mclk);
    #1 i_addr = a;
    @(posedge i_mclk);
    #1 chk($sformatf("region %h", a), {5'h00, o_region}, {5'h00, r});
  endtask : dec
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // Ports A and C: mixed directions, pins against latches
  task automatic t_ports();
    for (int i = 4; i < 8; i++) rd(i[12:0], 8'h00);
    wr(13'h0000, 8'ha5);
    chk("a oe_n", a_oe_n, 8'hff);
    chk("irq_n", {7'h00, o_irq_n}, 8'h00);
    chk("pullup", o_pull, 8'h01);
    rd(13'h0000, 8'h3c);
    wr(13'h0004, 8'h0f);
    chk("a oe_n", a_oe_n, 8'hf0);
    chk("a out", a_out & 8'h0f, 8'h05);
    rd(13'h0000, 8'h35);
    pat_a = 8'hc2;
    rd(13'h0000, 8'hc5);
    chk("irq_n", {7'h00, o_irq_n}, 8'h01);
    wr(13'h0006, 8'hc3);
    wr(13'h0002, 8'h5a);
    chk("c oe_n", c_oe_n, 8'h3c);
    rd(13'h0002, 8'h4e);
  endtask : t_ports
  // Narrow ports B and D, capture pin
  task automatic t_narrow();
    pat_b = 3'h5;
    rd(13'h0001, 8'ha0);
    pat_d = 1'b1;
    rd(13'h0003, 8'h20);
    wr(13'h0005, 8'hff);
    rd(13'h0005, 8'he0);
    wr(13'h0001, 8'hff);
    chk("b oe_n", {5'h00, b_oe_n}, 8'h00);
    rd(13'h0001, 8'he0);
    wr(13'h0007, 8'hff);
    rd(13'h0007, 8'h20);
    wr(13'h0003, 8'hff);
    chk("d pin", {6'h00, d_oe_n, d_out}, 8'h01);
    rd(13'h0003, 8'h20);
    i_cap = 1'b1;
    rd(13'h0003, 8'ha0);
    chk("cap level", {7'h00, cap_lvl}, 8'h01);
  endtask : t_narrow
  // Reset in mid-run keeps latches, clears directions
  task automatic t_rereset();
    @(posedge i_mclk);
    #1 i_rstn = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    chk("a oe_n", a_oe_n, 8'hff);
    rd(13'h0006, 8'h00);
    wr(13'h0004, 8'hff);
    chk("a latch", a_out, 8'ha5);
  endtask : t_rereset
  // Address map and RAM
  task automatic t_map();
    dec(13'h001f, REG_IO);
    dec(13'h004f, REG_PZ_ROM);
    chk("secure", {7'h00, o_secure}, 8'h01);
    dec(13'h0050, REG_RAM);
    chk("secure", {7'h00, o_secure}, 8'h00);
    chk("stack", {7'h00, o_stack}, 8'h00);
    dec(13'h10ff, REG_MAIN_ROM);
    dec(13'h1100, REG_NONE);
    dec(13'h1fef, REG_SELFCHK);
    dec(13'h1ff0, REG_VECTORS);
    dec(13'h00c0, REG_RAM);
    chk("stack", {7'h00, o_stack}, 8'h01);
    wr(13'h0050, 8'h11);
    wr(13'h00ff, 8'hee);
    wr(13'h0100, 8'h77);
    rd(13'h0050, 8'h11);
    rd(13'h00ff, 8'hee);
    rd(13'h0100, 8'h00);
    rd(13'h0010, 8'h00);
  endtask : t_map
  // Main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    t_ports();
    t_narrow();
    t_rereset();
    t_map();
    print_verdict();
  end
  // Watchdog
  initial begin
    #100us;
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
bind ppd_top ppd_monitor u_mon (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rvalid(o_rvalid), .o_region(o_region),
  .o_stack_win(o_stack_win), .o_keyscan_port_pin(o_keyscan_port_pin),
  .o_keyscan_port_pin_oe_n(o_keyscan_port_pin_oe_n),
  .o_high_drive_port_pin_oe_n(o_high_drive_port_pin_oe_n),
  .i_capture_input_pin(i_capture_input_pin), .o_capture_level(o_capture_level));
